// *** prescaler_params.svh ***
`ifndef PRESCALER_PARAMS_SVH
`define PRESCALER_PARAMS_SVH
`define TIMER_COUNT_ADDR       8'h01
`define INTERRUPT_CONTROL_ADDR 8'h0b
`define OPTION_CONFIG_ADDR     8'h81
`define PORT_A_DIRECTION_ADDR  8'h85
`define OPTION_CONFIG_RESET    8'hff
`define PORT_A_DIRECTION_RESET 8'h1f
`define PORT_A_DIRECTION_MASK  8'h1f
`define INTERRUPT_CONTROL_RESET 8'h00
`define TIMER_COUNT_RESET      8'h00
`define DIVIDER_RESET          8'h00
`define ASSIGN_BIT             3
`define RATIO_MSB              2
`define RATIO_LSB              0
`define TIMER_OVF_FLAG_BIT     2
`define WATCHDOG_RESET_WIDTH   8'h00
`endif

// *** prescaler_pkg.sv ***
`default_nettype none
package prescaler_pkg;
  typedef enum logic {
    assign_timer_t_val,
    assign_watchdog_t_val
  } divider_owner_t;
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// *** divider_tap.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "prescaler_params.svh"
// Wrap pulse from the shared counter at the chosen ratio
module divider_tap
  import prescaler_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Counter and selection
  input  wire logic [WIDTH-1:0] count_in,
  input  wire logic [2:0]       ratio_in,
  input  wire logic             for_timer_in,
  input  wire logic             step_in,
  // Result
  output logic                  wrap_out
);
  logic [WIDTH-1:0] mask_w;
  logic [3:0]       bits_w;
  assign bits_w   = for_timer_in ? ({1'b0, ratio_in} + 4'h1) : {1'b0, ratio_in};
  assign mask_w   = WIDTH'((9'h001 << bits_w) - 9'h001);
  assign wrap_out = step_in && ((count_in & mask_w) == mask_w);
endmodule
`default_nettype wire

// *** watchdog_core.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "prescaler_params.svh"
// Watchdog counter; overflow requests a device reset
module watchdog_core
  import prescaler_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  // Control
  input  wire logic enable_in,
  input  wire logic clear_in,
  input  wire logic count_in,
  // Status
  output logic      timeout_out
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic             timeout_next;
  logic             overflow_w;
  assign overflow_w   = enable_in && count_in && (&count_reg) && !clear_in;
  assign count_next   = clear_in ? '0 : (enable_in && count_in) ? count_reg + 1'b1 : count_reg;
  assign timeout_next = overflow_w;
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_reg   <= '0;
      timeout_out <= 1'b0;
    end else begin
      count_reg   <= count_next;
      timeout_out <= timeout_next;
    end
  end
endmodule
`default_nettype wire

// *** shared_timer_wdt_prescaler.sv ***
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "prescaler_params.svh"
// What this block does
// - One 8-bit dividing counter, prescaler for timer or postscaler for watchdog.
// - Divider serves one consumer; the other runs undivided.
// - Option bit 3 picks consumer, bits 2..0 pick ratio.
// - Timer-assigned: any timer count write clears the divider.
// - Watchdog-assigned: watchdog clear zeroes watchdog and divider.
// - Divider count is not addressable; only indirect clearing.
// - Assignment bit may be rewritten at any time.
// - Unimplemented bits read zero, writes ignored.
module shared_timer_wdt_prescaler
  import prescaler_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  // Register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // Core events
  input  wire logic       watchdog_clear_instruction_in,
  input  wire logic       watchdog_enable_in,
  input  wire logic       count_edge_in,
  input  wire logic       watchdog_tick_in,
  // Status
  output logic            timer_tick_out,
  output logic            watchdog_reset_out,
  output logic      [7:0] option_config_out
);
  // Pin-sourced inputs pass two flops
  logic [1:0] edge_sync_reg;
  logic [1:0] wdt_sync_reg;
  logic [1:0] en_sync_reg;
  logic       edge_prev_reg;
  logic       wdt_prev_reg;
  logic       edge_rise_w;
  logic       wdt_rise_w;

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      edge_sync_reg <= 2'h0;
      wdt_sync_reg  <= 2'h0;
      en_sync_reg   <= 2'h0;
      edge_prev_reg <= 1'b0;
      wdt_prev_reg  <= 1'b0;
    end else begin
      edge_sync_reg <= {edge_sync_reg[0], count_edge_in};
      wdt_sync_reg  <= {wdt_sync_reg[0], watchdog_tick_in};
      en_sync_reg   <= {en_sync_reg[0], watchdog_enable_in};
      edge_prev_reg <= edge_sync_reg[1];
      wdt_prev_reg  <= wdt_sync_reg[1];
    end
  end
  assign edge_rise_w = edge_sync_reg[1] && !edge_prev_reg;
  assign wdt_rise_w  = wdt_sync_reg[1] && !wdt_prev_reg;

  // Registers
  byte_t timer_count_reg;
  byte_t timer_count_next;
  byte_t interrupt_control_reg;
  byte_t interrupt_control_next;
  byte_t option_config_reg;
  byte_t option_config_next;
  byte_t port_a_direction_reg;
  byte_t port_a_direction_next;
  byte_t divider_reg;
  byte_t divider_next;
  byte_t rdata_next;

  function automatic logic hit(input byte_t a, input byte_t target);
    hit = (a == target);
  endfunction

  logic wr_timer_w;
  logic wr_interrupt_control_w;
  logic wr_option_w;
  logic wr_porta_w;
  assign wr_timer_w  = wr_in && hit(addr_in, `TIMER_COUNT_ADDR);
  assign wr_interrupt_control_w = wr_in && hit(addr_in, `INTERRUPT_CONTROL_ADDR);
  assign wr_option_w = wr_in && hit(addr_in, `OPTION_CONFIG_ADDR);
  assign wr_porta_w  = wr_in && hit(addr_in, `PORT_A_DIRECTION_ADDR);

  logic       divider_assign_select;
  logic [2:0] divide_ratio_field;
  logic       to_timer_w;
  assign divider_assign_select = option_config_reg[`ASSIGN_BIT];
  assign divide_ratio_field    = option_config_reg[`RATIO_MSB:`RATIO_LSB];
  assign to_timer_w            = !divider_assign_select;

  // steer input to the divider or bypass
  logic div_step_w;
  logic div_wrap_w;
  assign div_step_w = to_timer_w ? edge_rise_w : wdt_rise_w;

  divider_tap #(
    .WIDTH (8)
  ) u_tap (
    .count_in     (divider_reg),
    .ratio_in     (divide_ratio_field),
    .for_timer_in (to_timer_w),
    .step_in      (div_step_w),
    .wrap_out     (div_wrap_w)
  );

  logic clr_by_timer_w;
  logic clr_by_wdt_w;
  // assignment change restarts count, avoids stray wrap
  logic assign_change_w;
  assign clr_by_timer_w  = to_timer_w && wr_timer_w;
  assign clr_by_wdt_w    = divider_assign_select && watchdog_clear_instruction_in;
  assign assign_change_w = wr_option_w && (wdata_in[`ASSIGN_BIT] != divider_assign_select);

  // shared 8-bit divider, only indirect clearing
  assign divider_next = (clr_by_timer_w || clr_by_wdt_w || assign_change_w) ? `DIVIDER_RESET :
                        div_step_w ? divider_reg + 8'h01 : divider_reg;

  logic timer_inc_w;
  logic wdt_inc_w;
  assign timer_inc_w = to_timer_w ? (div_wrap_w && !assign_change_w) : edge_rise_w;
  assign wdt_inc_w   = divider_assign_select ? (div_wrap_w && !assign_change_w) : wdt_rise_w;

  // Tick only when the count really moves; a write wins that cycle
  logic timer_step_w;
  logic timer_ovf_w;
  assign timer_step_w     = timer_inc_w && !wr_timer_w;
  assign timer_ovf_w      = timer_step_w && (timer_count_reg == 8'hff);
  assign timer_count_next = wr_timer_w ? wdata_in : timer_inc_w ? timer_count_reg + 8'h01
                                                                : timer_count_reg;

  // Overflow flag: hardware set beats software clear
  assign interrupt_control_next =
      (wr_interrupt_control_w ? wdata_in : interrupt_control_reg) |
      (timer_ovf_w ? (8'h01 << `TIMER_OVF_FLAG_BIT) : 8'h00);
  assign option_config_next = wr_option_w ? wdata_in : option_config_reg;
  assign port_a_direction_next = wr_porta_w ? (wdata_in & `PORT_A_DIRECTION_MASK)
                                            : port_a_direction_reg;

  assign rdata_next = !rd_in ? 8'h00 :
                      hit(addr_in, `TIMER_COUNT_ADDR)       ? timer_count_reg :
                      hit(addr_in, `INTERRUPT_CONTROL_ADDR) ? interrupt_control_reg :
                      hit(addr_in, `OPTION_CONFIG_ADDR)     ? option_config_reg :
                      hit(addr_in, `PORT_A_DIRECTION_ADDR)  ? port_a_direction_reg : 8'h00;

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      timer_count_reg       <= `TIMER_COUNT_RESET;
      interrupt_control_reg <= `INTERRUPT_CONTROL_RESET;
      option_config_reg     <= `OPTION_CONFIG_RESET;
      port_a_direction_reg  <= `PORT_A_DIRECTION_RESET;
      divider_reg           <= `DIVIDER_RESET;
      rdata_out             <= 8'h00;
      timer_tick_out        <= 1'b0;
      option_config_out     <= `OPTION_CONFIG_RESET;
    end else begin
      timer_count_reg       <= timer_count_next;
      interrupt_control_reg <= interrupt_control_next;
      option_config_reg     <= option_config_next;
      port_a_direction_reg  <= port_a_direction_next;
      divider_reg           <= divider_next;
      rdata_out             <= rdata_next;
      timer_tick_out        <= timer_step_w;
      option_config_out     <= option_config_next;
    end
  end

  // Watchdog counter, cleared by the clear instruction in either assignment
  watchdog_core #(
    .WIDTH (8)
  ) u_wdt (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .enable_in   (en_sync_reg[1]),
    .clear_in    (watchdog_clear_instruction_in),
    .count_in    (wdt_inc_w),
    .timeout_out (watchdog_reset_out)
  );

  property p_timer_clear;
    @(posedge sys_clk_in) disable iff (reset_in)
      (wr_timer_w && to_timer_w) |=> (divider_reg == 8'h00);
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("divider not cleared");

  property p_wdt_clear;
    @(posedge sys_clk_in) disable iff (reset_in)
      (watchdog_clear_instruction_in && divider_assign_select) |=> (divider_reg == 8'h00);
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("divider kept count");

  property p_porta_mask;
    @(posedge sys_clk_in) disable iff (reset_in)
      (port_a_direction_reg[7:5] == 3'h0);
  endproperty
  a_porta_mask: assert property (p_porta_mask) else $error("reserved bits set");

  property p_read_latency;
    @(posedge sys_clk_in) disable iff (reset_in)
      (rd_in && hit(addr_in, `OPTION_CONFIG_ADDR)) |=> (rdata_out == $past(option_config_reg));
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("bad option read");

  property p_bypass;
    @(posedge sys_clk_in) disable iff (reset_in)
      (divider_assign_select && edge_rise_w && !wr_timer_w) |=> timer_tick_out;
  endproperty
  a_bypass: assert property (p_bypass) else $error("timer not undivided");

  property p_wrap_only;
    @(posedge sys_clk_in) disable iff (reset_in)
      (to_timer_w && timer_inc_w) |-> div_wrap_w && divider_reg[0];
  endproperty
  a_wrap_only: assert property (p_wrap_only) else $error("timer count without wrap");

  property p_no_switch_count;
    @(posedge sys_clk_in) disable iff (reset_in)
      assign_change_w |=> !timer_tick_out || $past(divider_assign_select);
  endproperty
  a_no_switch_count: assert property (p_no_switch_count) else $error("spurious count");

  property p_divider_step;
    @(posedge sys_clk_in) disable iff (reset_in)
      (div_step_w && !clr_by_timer_w && !clr_by_wdt_w && !assign_change_w)
        |=> (divider_reg == $past(divider_reg) + 8'h01);
  endproperty
  a_divider_step: assert property (p_divider_step) else $error("divider stalled");

  property p_switch_live;
    @(posedge sys_clk_in) disable iff (reset_in)
      wr_option_w |=> (divider_assign_select == $past(wdata_in[3]));
  endproperty
  a_switch_live: assert property (p_switch_live) else $error("assign not updated");

  property p_wdt_bypass;
    @(posedge sys_clk_in) disable iff (reset_in)
      (to_timer_w && wdt_rise_w) |-> wdt_inc_w;
  endproperty
  a_wdt_bypass: assert property (p_wdt_bypass) else $error("watchdog not undivided");

  property p_switch_clear;
    @(posedge sys_clk_in) disable iff (reset_in)
      assign_change_w |=> (divider_reg == 8'h00);
  endproperty
  a_switch_clear: assert property (p_switch_clear) else $error("divider kept on switch");

  property p_clear_quiet;
    @(posedge sys_clk_in) disable iff (reset_in)
      watchdog_clear_instruction_in |=> !watchdog_reset_out;
  endproperty
  a_clear_quiet: assert property (p_clear_quiet) else $error("reset despite clear");

  property p_dog_disabled;
    @(posedge sys_clk_in) disable iff (reset_in)
      !en_sync_reg[1] |=> !watchdog_reset_out;
  endproperty
  a_dog_disabled: assert property (p_dog_disabled) else $error("idle watchdog fired");

  property p_tick_single;
    @(posedge sys_clk_in) disable iff (reset_in)
      timer_tick_out |=> !timer_tick_out;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("timer tick too long");

  property p_dog_single;
    @(posedge sys_clk_in) disable iff (reset_in)
      watchdog_reset_out |=> !watchdog_reset_out;
  endproperty
  a_dog_single: assert property (p_dog_single) else $error("watchdog reset too long");

  property p_ovf_flag;
    @(posedge sys_clk_in) disable iff (reset_in)
      timer_ovf_w |=> interrupt_control_reg[`TIMER_OVF_FLAG_BIT];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag lost");

  property p_timer_load;
    @(posedge sys_clk_in) disable iff (reset_in)
      wr_timer_w |=> (timer_count_reg == $past(wdata_in));
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("timer write lost");

  property p_timer_step;
    @(posedge sys_clk_in) disable iff (reset_in)
      timer_step_w |=> (timer_count_reg == $past(timer_count_reg) + 8'h01);
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer did not advance");

  property p_timer_hold;
    @(posedge sys_clk_in) disable iff (reset_in)
      (!timer_inc_w && !wr_timer_w) |=> $stable(timer_count_reg);
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("timer moved unasked");

  property p_rdata_idle;
    @(posedge sys_clk_in) disable iff (reset_in)
      !rd_in |=> (rdata_out == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without strobe");

  property p_unmapped_read;
    @(posedge sys_clk_in) disable iff (reset_in)
      (rd_in && !hit(addr_in, `TIMER_COUNT_ADDR) && !hit(addr_in, `INTERRUPT_CONTROL_ADDR)
        && !hit(addr_in, `OPTION_CONFIG_ADDR) && !hit(addr_in, `PORT_A_DIRECTION_ADDR))
        |=> (rdata_out == 8'h00);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("stray read data");

  property p_porta_read;
    @(posedge sys_clk_in) disable iff (reset_in)
      (rd_in && hit(addr_in, `PORT_A_DIRECTION_ADDR)) |=> (rdata_out[7:5] == 3'h0);
  endproperty
  a_porta_read: assert property (p_porta_read) else $error("reserved bits read");

  property p_wdt_wrap_only;
    @(posedge sys_clk_in) disable iff (reset_in)
      (divider_assign_select && wdt_inc_w) |-> div_wrap_w;
  endproperty
  a_wdt_wrap_only: assert property (p_wdt_wrap_only) else $error("watchdog count no wrap");

  property p_option_copy;
    @(posedge sys_clk_in) disable iff (reset_in)
      (option_config_out == option_config_reg);
  endproperty
  a_option_copy: assert property (p_option_copy) else $error("option copy differs");

  c_timer_tick: cover property (@(posedge sys_clk_in) disable iff (reset_in) timer_tick_out);
  c_wdt_reset: cover property (@(posedge sys_clk_in) disable iff (reset_in) watchdog_reset_out);
  c_switch: cover property (@(posedge sys_clk_in) disable iff (reset_in) assign_change_w);
  c_timer_ovf: cover property (@(posedge sys_clk_in) disable iff (reset_in) timer_ovf_w);
  c_dog_clear: cover property (@(posedge sys_clk_in) disable iff (reset_in) clr_by_wdt_w);
endmodule
`default_nettype wire

// *** shared_timer_wdt_prescaler_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "prescaler_params.svh"
module shared_timer_wdt_prescaler_tb
  import prescaler_pkg::*;
;
  // Long enough for all tests, short enough to catch a hang
  localparam int cycle_limit = 20000;
  logic  sys_clk_in = 1'h0;
  logic  reset_in   = 1'h1;
  byte_t addr_in    = 8'h00;
  byte_t wdata_in   = 8'h00;
  logic  wr_in      = 1'h0;
  logic  rd_in      = 1'h0;
  logic  clear_in   = 1'h0;
  logic  dog_en     = 1'h0;
  logic  edge_in    = 1'h0;
  logic  dog_tick   = 1'h0;
  byte_t rdata_out;
  byte_t option_config_out;
  logic  timer_tick_out;
  logic  watchdog_reset_out;
  byte_t val;
  int    error_cnt = 0;
  int    n_tests   = 0;
  int    cycles    = 0;
  int    tick_cnt  = 0;
  int    dog_cnt   = 0;
  int    base_t    = 0;
  int    base_d    = 0;

  shared_timer_wdt_prescaler uut (
    .sys_clk_in                    (sys_clk_in),
    .reset_in                      (reset_in),
    .addr_in                       (addr_in),
    .wdata_in                      (wdata_in),
    .wr_in                         (wr_in),
    .rd_in                         (rd_in),
    .rdata_out                     (rdata_out),
    .watchdog_clear_instruction_in (clear_in),
    .watchdog_enable_in            (dog_en),
    .count_edge_in                 (edge_in),
    .watchdog_tick_in              (dog_tick),
    .timer_tick_out                (timer_tick_out),
    .watchdog_reset_out            (watchdog_reset_out),
    .option_config_out             (option_config_out)
  );

  always #50 sys_clk_in = ~sys_clk_in;

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Output pulses are counted, tests compare the difference
  always @(posedge sys_clk_in) begin
    cycles++;
    if (timer_tick_out === 1'h1) tick_cnt++;
    if (watchdog_reset_out === 1'h1) dog_cnt++;
    if (cycles == cycle_limit) begin
      error_cnt++;
      stop_test;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input byte_t a, input byte_t d);
    @(posedge sys_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'h1;
    @(posedge sys_clk_in);
    wr_in <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input byte_t a, input byte_t exp);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in   <= 1'h1;
    @(posedge sys_clk_in);
    rd_in <= 1'h0;
    #1 val = rdata_out;
    check(val, exp);
  endtask

  task automatic clear_dog;
    @(posedge sys_clk_in);
    clear_in <= 1'h1;
    @(posedge sys_clk_in);
    clear_in <= 1'h0;
    repeat (2) @(posedge sys_clk_in);
  endtask

  // Slow pulses so every one survives the input synchroniser
  task automatic pulse(input bit dog, input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      if (dog) dog_tick <= 1'h1;
      else edge_in <= 1'h1;
      repeat (2) @(posedge sys_clk_in);
      dog_tick <= 1'h0;
      edge_in  <= 1'h0;
      repeat (3) @(posedge sys_clk_in);
    end
    repeat (4) @(posedge sys_clk_in);
  endtask

  task automatic mark;
    #1;
    base_t = tick_cnt;
    base_d = dog_cnt;
  endtask

  task automatic ticks(input int t, input int d);
    check(tick_cnt - base_t, t);
    check(dog_cnt - base_d, d);
  endtask

  task automatic test_reset;
    rdc(8'h81, 8'hff);
    rdc(8'h85, 8'h1f);
    rdc(8'h01, 8'h00);
    rdc(8'h0b, 8'h00);
    check(option_config_out, 8'hff);
    $display("Test reset done");
  endtask

  task automatic test_regs;
    wr(8'h85, 8'hff);
    rdc(8'h85, 8'h1f);
    wr(8'h40, 8'h5a);
    rdc(8'h40, 8'h00);
    wr(8'h81, 8'hfa);
    @(posedge sys_clk_in);
    check(option_config_out, 8'hfa);
    wr(8'h81, 8'hff);
    $display("Test registers done");
  endtask

  task automatic test_timer_ratio;
    for (int r = 0; r < 8; r++) begin
      clear_dog;
      wr(8'h81, 8'hf0 | byte_t'(r));
      wr(8'h01, 8'h00);
      mark;
      pulse(1'b0, (2 << r) - 1);
      ticks(0, 0);
      pulse(1'b0, 1);
      ticks(1, 0);
      rdc(8'h01, 8'h01);
    end
    $display("Test timer ratios done");
  endtask

  task automatic test_timer_clear;
    wr(8'h81, 8'hf1);
    wr(8'h01, 8'h10);
    mark;
    pulse(1'b0, 3);
    wr(8'h01, 8'h20);
    pulse(1'b0, 3);
    ticks(0, 0);
    pulse(1'b0, 1);
    ticks(1, 0);
    rdc(8'h01, 8'h21);
    $display("Test timer clear done");
  endtask

  task automatic test_dog_undivided;
    wr(8'h81, 8'hf7);
    dog_en <= 1'h1;
    repeat (4) @(posedge sys_clk_in);
    clear_dog;
    mark;
    pulse(1'b1, 255);
    ticks(0, 0);
    pulse(1'b1, 1);
    ticks(0, 1);
    $display("Test watchdog undivided done");
  endtask

  task automatic test_switch;
    mark;
    clear_dog;
    wr(8'h01, 8'h00);
    wr(8'h81, 8'hff);
    clear_dog;
    wr(8'h81, 8'hf9);
    ticks(0, 0);
    pulse(1'b1, 1);
    clear_dog;
    mark;
    pulse(1'b1, 511);
    ticks(0, 0);
    pulse(1'b1, 1);
    ticks(0, 1);
    $display("Test switch to watchdog done");
  endtask

  task automatic test_timer_undivided;
    wr(8'h01, 8'hff);
    mark;
    pulse(1'b0, 1);
    ticks(1, 0);
    rdc(8'h01, 8'h00);
    rdc(8'h0b, 8'h04);
    $display("Test timer undivided done");
  endtask

  // Ratio code zero gives the watchdog no division at all
  task automatic test_dog_ratio0;
    wr(8'h81, 8'hf8);
    clear_dog;
    mark;
    pulse(1'b1, 255);
    ticks(0, 0);
    pulse(1'b1, 1);
    ticks(0, 1);
    $display("Test watchdog ratio zero done");
  endtask

  // Reset after activity must bring back the documented values
  task automatic test_mid_reset;
    @(posedge sys_clk_in);
    reset_in <= 1'h1;
    repeat (4) @(posedge sys_clk_in);
    reset_in <= 1'h0;
    @(posedge sys_clk_in);
    rdc(8'h81, 8'hff);
    rdc(8'h0b, 8'h00);
    rdc(8'h01, 8'h00);
    check(option_config_out, 8'hff);
    $display("Test mid-run reset done");
  endtask

  initial begin
    repeat (16) @(posedge sys_clk_in);
    reset_in <= 1'h0;
    @(posedge sys_clk_in);
    test_reset;
    test_regs;
    test_timer_ratio;
    test_timer_clear;
    test_dog_undivided;
    test_switch;
    test_dog_ratio0;
    test_timer_undivided;
    test_mid_reset;
    stop_test;
  end
endmodule
`default_nettype wire
